// ==== rtl/ddr_link_pkg.sv ====
package ddr_link_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// command/address bus layout: rise word carries op, bank and upper address,
	// fall word carries the lower address
	localparam int CA_W    = 10;
	localparam int OP_W    = 3;
	localparam int OP_HI   = 9;
	localparam int OP_LO   = 7;
	localparam int BANK_HI = 6;
	localparam int BANK_LO = 5;
	localparam int AHI_HI  = 4;
	localparam int ADDR_W  = CA_W + AHI_HI + 1;

	////////////////////////////////////////////////////////////////////////////////
	// banks and prefetch
	localparam int BANKS    = 4;
	localparam int BANK_W   = 2;
	localparam int PREFETCH = 4;
	localparam int BEAT_W   = 2;

	////////////////////////////////////////////////////////////////////////////////
	// link clock made by the controller from the system clock
	localparam int SYS_PERIOD_NS = 10;
	localparam int CK_PERIOD_NS  = 80;
	localparam int LINK_DIV      = CK_PERIOD_NS / SYS_PERIOD_NS;
	localparam int HALF          = LINK_DIV / 2;
	localparam int PH_W          = $clog2(LINK_DIV);

	localparam logic [PH_W-1:0] CK_LO_END = PH_W'(LINK_DIV - 1);
	localparam logic [PH_W-1:0] CK_HI_END = PH_W'(HALF - 1);
	localparam logic [PH_W-1:0] RISE_PREP = PH_W'(LINK_DIV - 3);
	localparam logic [PH_W-1:0] FALL_PREP = PH_W'(HALF - 3);
	localparam logic [PH_W-1:0] SMP_RISE  = PH_W'(0);
	localparam logic [PH_W-1:0] SMP_FALL  = PH_W'(HALF);

	// read samples skipped after the command, and the last one taken
	localparam int RD_SKIP = 3;
	localparam int RD_LAST = RD_SKIP + PREFETCH - 1;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD  = 3'h2,
		CMD_WR  = 3'h3,
		CMD_PRE = 3'h4,
		CMD_RST = 3'h5
	} cmd_t;

	localparam logic [CA_W-1:0] CA_IDLE = 10'h000;

endpackage

// ==== rtl/ddr_link_if.sv ====
`timescale 1ns/1ns
interface ddr_link_if import ddr_link_pkg::*; #(parameter int DQ_W = 8) ();

	logic            link_ck;
	logic [CA_W-1:0] cmd_addr_bus;
	logic [DQ_W-1:0] dq_ctl_o;
	logic            dq_ctl_oe_n;
	logic [DQ_W-1:0] dq_dev_o;
	logic            dq_dev_oe_n;
	logic [DQ_W-1:0] dq;

	// resolved data wire; an undriven bus reads as zero
	assign dq = !dq_dev_oe_n ? dq_dev_o : (!dq_ctl_oe_n ? dq_ctl_o : '0);

	modport ctl (output link_ck, cmd_addr_bus, dq_ctl_o, dq_ctl_oe_n, input dq);
	modport dev (input link_ck, cmd_addr_bus, dq, output dq_dev_o, dq_dev_oe_n);

endinterface // ddr_link_if

// ==== rtl/ddr_dev_end.sv ====
//Contract
//- ten-bit bus multiplexes command, address, bank
//- one cycle per command, both edges
//- data pins move two bits per cycle
//- one 4n core transfer per access
//- bursts walk consecutive columns in wrap order
//- controller activates a row before access
//- activate selects bank and row captured
//- read/write selects bank and start column
//- controller runs initialisation before normal use
`timescale 1ns/1ns
module ddr_dev_end import ddr_link_pkg::*; #(
	parameter int DQ_W  = 8,
	parameter int ROW_W = 3,
	parameter int COL_W = 4
) (
	// system
	input  wire logic             CLK_SYS,
	input  wire logic             RST,
	// link
	ddr_link_if.dev               LINK,
	// status
	output logic                  READY,
	output logic [BANKS-1:0]      BANK_OPEN,
	output logic                  ILLEGAL_CMD
);

	localparam int CW_W  = COL_W - BEAT_W;
	localparam int IDX_W = BANK_W + ROW_W + CW_W;
	localparam int WORDS = 2 ** IDX_W;
	localparam int WORD_W = PREFETCH * DQ_W;

	typedef enum logic [1:0] {
		D_IDLE = 2'h0,
		D_RD   = 2'h1,
		D_REL  = 2'h2,
		D_WR   = 2'h3
	} dstate_t;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic              ck_s1_q;
	logic              ck_s2_q;
	logic              ck_s3_q;
	logic [CA_W-1:0]   ca_s1_q;
	logic [CA_W-1:0]   ca_s2_q;
	logic [DQ_W-1:0]   dq_s1_q;
	logic [DQ_W-1:0]   dq_s2_q;
	logic              rise;
	logic              fall;
	logic              any_edge;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_s3_q <= 1'b0;
			ca_s1_q <= CA_IDLE;
			ca_s2_q <= CA_IDLE;
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else begin
			ck_s1_q <= LINK.link_ck;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
			ca_s1_q <= LINK.cmd_addr_bus;
			ca_s2_q <= ca_s1_q;
			dq_s1_q <= LINK.dq;
			dq_s2_q <= dq_s1_q;
		end
	end

	assign rise     = ck_s2_q & ~ck_s3_q;
	assign fall     = ~ck_s2_q & ck_s3_q;
	assign any_edge = rise | fall;

	////////////////////////////////////////////////////////////////////////////////
	// command capture and decode

	logic [CA_W-1:0]   rise_word_q;
	cmd_t              op;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic              is_rw;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rise_word_q <= CA_IDLE;
		end else if (rise) begin
			rise_word_q <= ca_s2_q;
		end
	end

	// the command is complete once the falling half has been seen
	assign op    = cmd_t'(rise_word_q[OP_HI:OP_LO]);
	assign bank  = rise_word_q[BANK_HI:BANK_LO];
	assign addr  = {rise_word_q[AHI_HI:0], ca_s2_q};
	assign is_rw = (op == CMD_RD) || (op == CMD_WR);

	////////////////////////////////////////////////////////////////////////////////
	// readiness after the reset command

	logic ready_q;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ready_q <= 1'b0;
		end else if (fall && op == CMD_RST) begin
			ready_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bank state

	logic [BANKS-1:0] open_q;
	logic [ROW_W-1:0] row_q [BANKS];

	always_ff @(posedge CLK_SYS) begin
		if (RST || (fall && op == CMD_RST)) begin
			open_q <= '0;
			for (int b = 0; b < BANKS; b++) begin
				row_q[b] <= '0;
			end
		end else if (fall && ready_q) begin
			if (op == CMD_ACT) begin
				open_q[bank] <= 1'b1;
				row_q[bank]  <= addr[ROW_W-1:0];
			end else if (op == CMD_PRE) begin
				open_q[bank] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// access acceptance

	logic             access;
	logic             illegal_q;
	logic [IDX_W-1:0] idx;

	assign access = fall && ready_q && is_rw && open_q[bank];
	assign idx    = {bank, row_q[bank], addr[COL_W-1:BEAT_W]};

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= fall && ready_q && is_rw && !open_q[bank];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// core array and burst engine

	logic [WORD_W-1:0] mem [WORDS];
	dstate_t           dst_q;
	logic [BEAT_W-1:0] beat_q;
	logic [BEAT_W-1:0] start_q;
	logic [BEAT_W-1:0] lane;
	logic [IDX_W-1:0]  widx_q;
	logic [WORD_W-1:0] rword_q;
	logic [WORD_W-1:0] wbuf_q;
	logic              commit_q;
	logic [DQ_W-1:0]   dq_o_q;
	logic              dq_oe_n_q;

	// beats walk the four lanes from the start column, wrapping
	assign lane = start_q + beat_q;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dst_q    <= D_IDLE;
			beat_q   <= '0;
			start_q  <= '0;
			widx_q   <= '0;
			rword_q  <= '0;
			wbuf_q   <= '0;
			commit_q <= 1'b0;
		end else begin
			commit_q <= 1'b0;
			case (dst_q)
				D_IDLE: begin
					if (access) begin
						beat_q  <= '0;
						start_q <= addr[BEAT_W-1:0];
						widx_q  <= idx;
						if (op == CMD_RD) begin
							rword_q <= mem[idx];
							dst_q   <= D_RD;
						end else begin
							dst_q <= D_WR;
						end
					end
				end
				D_RD: begin
					if (any_edge) begin
						beat_q <= beat_q + 1'b1;
						if (beat_q == BEAT_W'(PREFETCH - 1)) begin
							dst_q <= D_REL;
						end
					end
				end
				D_REL: begin
					if (any_edge) begin
						dst_q <= D_IDLE;
					end
				end
				D_WR: begin
					if (any_edge) begin
						wbuf_q[lane*DQ_W +: DQ_W] <= dq_s2_q;
						beat_q <= beat_q + 1'b1;
						if (beat_q == BEAT_W'(PREFETCH - 1)) begin
							commit_q <= 1'b1;
							dst_q    <= D_IDLE;
						end
					end
				end
				default: begin
					dst_q <= D_IDLE;
				end
			endcase
		end
	end

	// whole prefetch word written in one cycle
	always_ff @(posedge CLK_SYS) begin
		if (commit_q) begin
			mem[widx_q] <= wbuf_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// data pin drive

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dq_o_q    <= '0;
			dq_oe_n_q <= 1'b1;
		end else if (dst_q == D_RD && any_edge) begin
			dq_o_q    <= rword_q[lane*DQ_W +: DQ_W];
			dq_oe_n_q <= 1'b0;
		end else if (dst_q == D_REL && any_edge) begin
			dq_oe_n_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign LINK.dq_dev_o    = dq_o_q;
	assign LINK.dq_dev_oe_n = dq_oe_n_q;
	assign READY            = ready_q;
	assign BANK_OPEN        = open_q;
	assign ILLEGAL_CMD      = illegal_q;

endmodule // ddr_dev_end

// ==== rtl/ddr_ctl_end.sv ====
`timescale 1ns/1ns
module ddr_wfifo #(
	parameter int W     = 32,
	parameter int DEPTH = 16
) (
	// system
	input  wire logic         clk,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   count_q;
	logic [AW:0]   count_d;
	logic          in_ready_q;
	logic          out_valid_q;
	logic          push;
	logic          pop;

	assign push = in_valid && in_ready_q;
	assign pop  = out_ready && out_valid_q;

	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q        <= '0;
			rd_q        <= '0;
			count_q     <= '0;
			in_ready_q  <= 1'b1;
			out_valid_q <= 1'b0;
		end else begin
			count_q     <= count_d;
			in_ready_q  <= count_d != (AW+1)'(DEPTH);
			out_valid_q <= count_d != '0;
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	assign in_ready  = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data  = mem[rd_q];

endmodule // ddr_wfifo

module ddr_ctl_end import ddr_link_pkg::*; #(
	parameter int DQ_W             = 8,
	parameter int ROW_W            = 3,
	parameter int COL_W            = 4,
	parameter int FIFO_DEPTH       = 16,
	parameter int INIT_LINK_CYCLES = 16
) (
	// system
	input  wire logic                     CLK_SYS,
	input  wire logic                     RST,
	// link
	ddr_link_if.ctl                       LINK,
	// requests
	input  wire logic                     REQ_VALID,
	input  wire cmd_t                     REQ_OP,
	input  wire logic [BANK_W-1:0]        REQ_BANK,
	input  wire logic [ROW_W-1:0]         REQ_ROW,
	input  wire logic [COL_W-1:0]         REQ_COL,
	output logic                          REQ_ACK,
	output logic                          REQ_ERR,
	// write data
	input  wire logic                     WD_VALID,
	input  wire logic [PREFETCH*DQ_W-1:0] WD_DATA,
	output logic                          WD_READY,
	// read data
	output logic                          RD_VALID,
	output logic [PREFETCH*DQ_W-1:0]      RD_DATA,
	// status
	output logic                          INIT_DONE
);

	localparam int WORD_W = PREFETCH * DQ_W;

	typedef enum logic [2:0] {
		C_INIT = 3'h0,
		C_IDLE = 3'h1,
		C_CMD  = 3'h2,
		C_WDAT = 3'h3,
		C_RDAT = 3'h4
	} cstate_t;

	////////////////////////////////////////////////////////////////////////////////
	// link clock divider

	logic [PH_W-1:0] cnt_q;
	logic            ck_q;
	logic            rprep;
	logic            fprep;
	logic            smp;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cnt_q <= '0;
			ck_q  <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == CK_LO_END) ? '0 : cnt_q + 1'b1;
			if (cnt_q == CK_LO_END) begin
				ck_q <= 1'b1;
			end else if (cnt_q == CK_HI_END) begin
				ck_q <= 1'b0;
			end
		end
	end

	assign rprep = cnt_q == RISE_PREP;
	assign fprep = cnt_q == FALL_PREP;
	assign smp   = (cnt_q == SMP_RISE) || (cnt_q == SMP_FALL);

	////////////////////////////////////////////////////////////////////////////////
	// request acceptance

	logic              f_valid;
	logic              f_pop;
	logic [WORD_W-1:0] f_data;
	cstate_t           st_q;
	logic [BANKS-1:0]  open_q;
	logic              take;
	logic              legal;
	logic              issue;
	logic [ADDR_W-1:0] addr;

	assign take  = rprep && st_q == C_IDLE && REQ_VALID && (REQ_OP != CMD_WR || f_valid);
	assign legal = (REQ_OP == CMD_ACT) || (REQ_OP == CMD_PRE) ||
		(((REQ_OP == CMD_RD) || (REQ_OP == CMD_WR)) && open_q[REQ_BANK]);
	assign issue = take && legal;
	assign f_pop = issue && REQ_OP == CMD_WR;
	assign addr  = (REQ_OP == CMD_ACT) ? ADDR_W'(REQ_ROW) : ADDR_W'(REQ_COL);

	ddr_wfifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.clk       (CLK_SYS),
		.rst       (RST),
		.in_valid  (WD_VALID),
		.in_ready  (WD_READY),
		.in_data   (WD_DATA),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	logic [15:0]       init_q;
	cmd_t              op_q;
	logic [BEAT_W-1:0] col_q;
	logic [BEAT_W-1:0] beat_q;
	logic [2:0]        smp_q;
	logic              init_end;
	logic              init_done_q;
	logic              ack_q;
	logic              err_q;

	assign init_end = st_q == C_INIT && rprep && init_q == 16'(INIT_LINK_CYCLES - 1);

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_q        <= C_INIT;
			init_q      <= '0;
			op_q        <= CMD_NOP;
			col_q       <= '0;
			beat_q      <= '0;
			smp_q       <= '0;
			init_done_q <= 1'b0;
			ack_q       <= 1'b0;
			err_q       <= 1'b0;
		end else begin
			ack_q <= take;
			err_q <= take && !legal;
			case (st_q)
				C_INIT: begin
					if (init_end) begin
						op_q <= CMD_RST;
						st_q <= C_CMD;
					end else if (rprep) begin
						init_q <= init_q + 1'b1;
					end
				end
				C_IDLE: begin
					if (issue) begin
						op_q  <= REQ_OP;
						col_q <= REQ_COL[BEAT_W-1:0];
						st_q  <= C_CMD;
					end
				end
				C_CMD: begin
					if (fprep) begin
						beat_q <= '0;
						smp_q  <= '0;
						if (op_q == CMD_RST) begin
							init_done_q <= 1'b1;
						end
						st_q <= (op_q == CMD_WR) ? C_WDAT : ((op_q == CMD_RD) ? C_RDAT : C_IDLE);
					end
				end
				C_WDAT: begin
					if (rprep || fprep) begin
						beat_q <= beat_q + 1'b1;
						if (beat_q == BEAT_W'(PREFETCH - 1)) begin
							st_q <= C_IDLE;
						end
					end
				end
				C_RDAT: begin
					if (smp) begin
						smp_q <= smp_q + 1'b1;
						if (smp_q == 3'(RD_LAST)) begin
							st_q <= C_IDLE;
						end
					end
				end
				default: begin
					st_q <= C_INIT;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			open_q <= '0;
		end else if (issue && REQ_OP == CMD_ACT) begin
			open_q[REQ_BANK] <= 1'b1;
		end else if (issue && REQ_OP == CMD_PRE) begin
			open_q[REQ_BANK] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command/address drive, changed mid-half away from link edges

	logic [CA_W-1:0] ca_q;
	logic [CA_W-1:0] fall_q;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ca_q   <= CA_IDLE;
			fall_q <= CA_IDLE;
		end else if (rprep) begin
			fall_q <= CA_IDLE;
			ca_q   <= CA_IDLE;
			if (issue) begin
				ca_q   <= {REQ_OP, REQ_BANK, addr[ADDR_W-1:CA_W]};
				fall_q <= addr[CA_W-1:0];
			end else if (init_end) begin
				ca_q <= {CMD_RST, (CA_W-OP_W)'(0)};
			end
		end else if (fprep) begin
			ca_q <= fall_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write data drive and read capture

	logic [WORD_W-1:0] wbuf_q;
	logic [DQ_W-1:0]   dq_o_q;
	logic              dq_oe_n_q;
	logic [DQ_W-1:0]   dq_s1_q;
	logic [DQ_W-1:0]   dq_s2_q;
	logic [WORD_W-1:0] rdata_q;
	logic              rd_valid_q;
	logic [BEAT_W-1:0] wlane;
	logic [BEAT_W-1:0] rlane;
	logic              rtake;

	assign wlane = col_q + beat_q;
	assign rlane = col_q + BEAT_W'(smp_q - 3'(RD_SKIP));
	assign rtake = st_q == C_RDAT && smp && smp_q >= 3'(RD_SKIP);

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			wbuf_q    <= '0;
			dq_o_q    <= '0;
			dq_oe_n_q <= 1'b1;
		end else begin
			if (f_pop) begin
				wbuf_q <= f_data;
			end
			if (st_q == C_WDAT && (rprep || fprep)) begin
				dq_o_q    <= wbuf_q[wlane*DQ_W +: DQ_W];
				dq_oe_n_q <= 1'b0;
			end else if (st_q == C_IDLE && rprep) begin
				dq_oe_n_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dq_s1_q    <= '0;
			dq_s2_q    <= '0;
			rdata_q    <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			dq_s1_q    <= LINK.dq;
			dq_s2_q    <= dq_s1_q;
			rd_valid_q <= rtake && smp_q == 3'(RD_LAST);
			if (rtake) begin
				rdata_q[rlane*DQ_W +: DQ_W] <= dq_s2_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign LINK.link_ck      = ck_q;
	assign LINK.cmd_addr_bus = ca_q;
	assign LINK.dq_ctl_o     = dq_o_q;
	assign LINK.dq_ctl_oe_n  = dq_oe_n_q;
	assign REQ_ACK           = ack_q;
	assign REQ_ERR           = err_q;
	assign RD_VALID          = rd_valid_q;
	assign RD_DATA           = rdata_q;
	assign INIT_DONE         = init_done_q;

endmodule // ddr_ctl_end

// ==== verif/ddr_link_assertions.sv ====
`timescale 1ns/1ns
module ddr_link_assertions import ddr_link_pkg::*; #(
	parameter int DQ_W = 8
) (
	// system
	input wire logic            CLK_SYS,
	input wire logic            RST,
	// link
	input wire logic            link_ck,
	input wire logic [CA_W-1:0] cmd_addr_bus,
	input wire logic [DQ_W-1:0] dq_ctl_o,
	input wire logic            dq_ctl_oe_n,
	input wire logic [DQ_W-1:0] dq_dev_o,
	input wire logic            dq_dev_oe_n
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	////////////////////////////////////////////////////////////////////////////////
	// rise word tracking
	logic [CA_W-1:0]   ca_q;
	cmd_t              last_op_q;
	logic [BANKS-1:0]  open_q;
	logic              init_q;
	logic              rise_w;
	cmd_t              op_w;
	logic [BANK_W-1:0] bank_w;

	assign op_w   = cmd_t'(cmd_addr_bus[OP_HI:OP_LO]);
	assign bank_w = cmd_addr_bus[BANK_HI:BANK_LO];
	assign rise_w = !link_ck && (cmd_addr_bus != ca_q) && (op_w != CMD_NOP);

	always_ff @(posedge CLK_SYS) begin
		ca_q <= cmd_addr_bus;
	end
	always_ff @(posedge CLK_SYS) begin
		if (RST) last_op_q <= CMD_NOP;
		else if (rise_w) last_op_q <= op_w;
	end
	always_ff @(posedge CLK_SYS) begin
		if (RST) init_q <= 1'b0;
		else if (rise_w && op_w == CMD_RST) init_q <= 1'b1;
	end
	always_ff @(posedge CLK_SYS) begin
		if (RST) open_q <= '0;
		else if (rise_w && op_w == CMD_ACT) open_q[bank_w] <= 1'b1;
		else if (rise_w && op_w == CMD_PRE) open_q[bank_w] <= 1'b0;
		else if (rise_w && op_w == CMD_RST) open_q <= '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	ck_shape_a: assert property ($rose(link_ck) |-> link_ck[*4] ##1 !link_ck[*4])
		else $error("link clock high or low time wrong");
	ca_hold_a: assert property (!$stable(cmd_addr_bus) |=> $stable(cmd_addr_bus)[*3])
		else $error("command word held too short");
	ca_edge_a: assert property (!$stable(cmd_addr_bus) |-> ##[1:3] $changed(link_ck))
		else $error("command word not followed by a link edge");
	one_driver_a: assert property (!(!dq_ctl_oe_n && !dq_dev_oe_n))
		else $error("both ends drive the data wire");
	wr_len_a: assert property ($fell(dq_ctl_oe_n) |->
		!dq_ctl_oe_n[*8] ##1 !dq_ctl_oe_n[*8] ##1 dq_ctl_oe_n)
		else $error("write burst length wrong");
	wr_beat_a: assert property (!dq_ctl_oe_n && !$stable(dq_ctl_o) |=>
		(dq_ctl_oe_n || $stable(dq_ctl_o))[*3])
		else $error("write beat held too short");
	rd_len_a: assert property ($fell(dq_dev_oe_n) |->
		!dq_dev_oe_n[*8] ##1 !dq_dev_oe_n[*4] ##[1:12] dq_dev_oe_n)
		else $error("read burst length wrong");
	rd_cause_a: assert property ($fell(dq_dev_oe_n) |-> last_op_q == CMD_RD)
		else $error("device drove data without a read");
	wr_cause_a: assert property ($fell(dq_ctl_oe_n) |-> last_op_q == CMD_WR)
		else $error("controller drove data without a write");
	act_first_a: assert property (rise_w && (op_w == CMD_RD || op_w == CMD_WR)
		|-> open_q[bank_w])
		else $error("access sent to a closed bank");
	init_first_a: assert property (rise_w && !init_q |-> op_w == CMD_RST)
		else $error("command sent before the reset command");

	wr_seen_c: cover property ($fell(dq_ctl_oe_n));
	rd_seen_c: cover property ($fell(dq_dev_oe_n));
	act_seen_c: cover property (rise_w && op_w == CMD_ACT);
endmodule // ddr_link_assertions

// ==== verif/ddr_command_data_access_tb_top.sv ====
`timescale 1ns/1ns
module ddr_command_data_access_tb_top import ddr_link_pkg::*;;
	logic        clk_sys, rst, req_valid, req_ack, req_err, wd_valid, wd_ready;
	logic        rd_valid, init_done, ready, ill, ready2, ill2;
	cmd_t        req_op;
	logic [1:0]  req_bank;
	logic [2:0]  req_row;
	logic [3:0]  req_col, bank_open, open2;
	logic [31:0] wd_data, rd_data;
	int          fail_count = 0, comparisons = 0, ill_cnt = 0, ill_main = 0, n;

	ddr_link_if ddr_link_if_i ();
	ddr_link_if fault_link ();
	ddr_ctl_end #(.INIT_LINK_CYCLES(2)) ddr_ctl_end_i (.CLK_SYS(clk_sys), .RST(rst),
		.LINK(ddr_link_if_i.ctl), .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_BANK(req_bank),
		.REQ_ROW(req_row), .REQ_COL(req_col), .REQ_ACK(req_ack), .REQ_ERR(req_err),
		.WD_VALID(wd_valid), .WD_DATA(wd_data), .WD_READY(wd_ready), .RD_VALID(rd_valid),
		.RD_DATA(rd_data), .INIT_DONE(init_done));
	ddr_dev_end ddr_dev_end_i (.CLK_SYS(clk_sys), .RST(rst),
		.LINK(ddr_link_if_i.dev), .READY(ready), .BANK_OPEN(bank_open), .ILLEGAL_CMD(ill));
	ddr_dev_end fault_dev_i (.CLK_SYS(clk_sys), .RST(rst),
		.LINK(fault_link.dev), .READY(ready2), .BANK_OPEN(open2), .ILLEGAL_CMD(ill2));
	ddr_link_assertions ddr_link_assertions_i (.CLK_SYS(clk_sys), .RST(rst),
		.link_ck(ddr_link_if_i.link_ck), .cmd_addr_bus(ddr_link_if_i.cmd_addr_bus),
		.dq_ctl_o(ddr_link_if_i.dq_ctl_o), .dq_ctl_oe_n(ddr_link_if_i.dq_ctl_oe_n),
		.dq_dev_o(ddr_link_if_i.dq_dev_o), .dq_dev_oe_n(ddr_link_if_i.dq_dev_oe_n));

	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (ill2 === 1'b1) ill_cnt++;
		if (ill === 1'b1) ill_main++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		if (fail_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [31:0] word(input int i);
		return 32'h76543210 ^ {4{8'(i * 17)}};
	endfunction
	task push(input int i);
		wd_data = word(i);
		wd_valid = 1'b1;
		n = 0;
		while (wd_ready !== 1'b1 && n < 100) begin tick(1); n++; end
		chk(32'(wd_ready), 32'h1);
		tick(1);
	endtask
	task req(input cmd_t op, input logic [1:0] b, input logic [2:0] r, input logic [3:0] c,
		input logic e);
		req_op = op; req_bank = b; req_row = r; req_col = c; req_valid = 1'b1;
		n = 0;
		do begin tick(1); n++; end while (req_ack !== 1'b1 && n < 400);
		req_valid = 1'b0;
		chk(32'(req_ack), 32'h1);
		chk(32'(req_err), 32'(e));
		if (!e && op != CMD_PRE) begin
			n = 0;
			while (ddr_link_if_i.cmd_addr_bus[OP_HI:OP_LO] !== op && n < 8) begin tick(1); n++; end
			chk(32'(ddr_link_if_i.cmd_addr_bus), 32'({op, b, 5'h00}));
			while (ddr_link_if_i.cmd_addr_bus[OP_HI:OP_LO] === op && n < 16) begin tick(1); n++; end
			chk(32'(ddr_link_if_i.cmd_addr_bus), (op == CMD_ACT) ? 32'(r) : 32'(c));
		end
	endtask
	task rd(input logic [1:0] b, input logic [3:0] c, input logic [31:0] exp);
		req(CMD_RD, b, 3'h0, c, 1'b0);
		n = 0;
		while (rd_valid !== 1'b1 && n < 100) begin tick(1); n++; end
		chk(32'(rd_valid), 32'h1);
		chk(rd_data, exp);
	endtask
	task lcyc(input logic [9:0] rw, input logic [9:0] fw);
		fault_link.cmd_addr_bus = rw; tick(2);
		fault_link.link_ck = 1'b1; tick(2);
		fault_link.cmd_addr_bus = fw; tick(2);
		fault_link.link_ck = 1'b0; tick(2);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		fail_count++;
		test_done;
	end
	initial begin
		rst = 1'b1; req_valid = 1'b0; req_op = CMD_NOP; req_bank = '0; req_row = '0;
		req_col = '0; wd_valid = 1'b0; wd_data = '0;
		fault_link.link_ck = 1'b0; fault_link.cmd_addr_bus = '0;
		fault_link.dq_ctl_o = '0; fault_link.dq_ctl_oe_n = 1'b1;
		repeat (10) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk(32'(ready), 32'h0);
		n = 0;
		while (init_done !== 1'b1 && n < 1000) begin tick(1); n++; end
		chk(32'(init_done), 32'h1);
		tick(40);
		chk(32'(ready), 32'h1);
		req(CMD_RD, 2'h1, 3'h0, 4'h0, 1'b1);
		req(CMD_NOP, 2'h0, 3'h0, 4'h0, 1'b1);
		req(CMD_RST, 2'h0, 3'h0, 4'h0, 1'b1);
		for (int i = 0; i < 4; i++) req(CMD_ACT, 2'(i), 3'h3, 4'h0, 1'b0);
		tick(40);
		chk(32'(bank_open), 32'hf);
		for (int i = 0; i < 16; i++) push(i);
		wd_valid = 1'b0;
		chk(32'(wd_ready), 32'h0);
		for (int i = 0; i < 16; i++) req(CMD_WR, 2'(i), 3'h3, {2'(i >> 2), 2'(i)}, 1'b0);
		chk(32'(wd_ready), 32'h1);
		for (int i = 0; i < 16; i++) rd(2'(i), {2'(i >> 2), ~2'(i)}, word(i));
		req(CMD_PRE, 2'h0, 3'h0, 4'h0, 1'b0);
		req(CMD_RD, 2'h0, 3'h0, 4'h0, 1'b1);
		req(CMD_ACT, 2'h0, 3'h5, 4'h0, 1'b0);
		push(20);
		wd_valid = 1'b0;
		req(CMD_WR, 2'h0, 3'h0, 4'h0, 1'b0);
		rd(2'h0, 4'h2, word(20));
		req(CMD_PRE, 2'h0, 3'h0, 4'h0, 1'b0);
		req(CMD_ACT, 2'h0, 3'h3, 4'h0, 1'b0);
		rd(2'h0, 4'h0, word(0));
		chk(32'(ill_main), 32'h0);
		lcyc({CMD_RD, 2'h0, 5'h00}, 10'h000);
		lcyc(10'h000, 10'h000);
		chk(32'(ready2), 32'h0);
		lcyc({CMD_RST, 2'h0, 5'h00}, 10'h000);
		lcyc(10'h000, 10'h000);
		lcyc(10'h000, 10'h000);
		chk(32'(ready2), 32'h1);
		lcyc({CMD_RD, 2'h1, 5'h00}, 10'h000);
		lcyc(10'h000, 10'h000);
		lcyc(10'h000, 10'h000);
		chk(32'(ill_cnt), 32'h1);
		chk(32'(fault_link.dq_dev_oe_n), 32'h1);
		lcyc({CMD_ACT, 2'h2, 5'h00}, 10'h006);
		lcyc(10'h000, 10'h000);
		lcyc(10'h000, 10'h000);
		chk(32'(open2), 32'h4);
		test_done;
	end
endmodule // ddr_command_data_access_tb_top
